// File: hw/meter_test_loop_pkg.sv
// Constants and types shared by the test-loop and accumulator logic
package meter_test_loop_pkg;

	// Clock and time base
	localparam int unsigned CLK_HZ          = 200_000_000;
	localparam int unsigned TICK_HZ         = 1000;
	localparam int unsigned TICK_CYCLES     = CLK_HZ / TICK_HZ;
	localparam int unsigned MS_PER_S        = 1000;
	localparam int unsigned S_PER_H         = 3600;

	// Test mode timing, each in its own unit
	localparam int unsigned TEST_TIMEOUT_H  = 9;
	localparam int unsigned TEST_TIMEOUT_MS = TEST_TIMEOUT_H * S_PER_H * MS_PER_S;
	localparam int unsigned EXIT_HOLD_S     = 5;
	localparam int unsigned EXIT_HOLD_MS    = EXIT_HOLD_S * MS_PER_S;
	localparam int unsigned LONG_PRESS_MS   = 1000;

	// Reconfiguration log limit
	localparam int unsigned RECONFIG_MAX    = 25;
	localparam int unsigned RECONFIG_W      = 5;

	// Menu indices of the test loop
	localparam logic [2:0]  MENU_FIRST      = 3'h1;
	localparam logic [2:0]  MENU_LAST       = 3'h6;
	localparam logic [2:0]  MENU_LAST_SEC   = 3'h3;
	localparam int unsigned MENU_W          = 3;

	// High-resolution register steps
	localparam int unsigned HR_ENERGY_STEP_WH = 1;
	localparam int unsigned HR_VOL_STEP_ML    = 10;

	// Volume resolution codes taken from the flow configuration code
	localparam logic [1:0]  RES_0_001_M3    = 2'h0;
	localparam logic [1:0]  RES_0_01_M3     = 2'h1;
	localparam logic [1:0]  RES_0_1_M3      = 2'h2;
	localparam logic [1:0]  RES_1_M3        = 2'h3;

	// Volume step in litres and accumulator factor in hundredths
	localparam int unsigned VOL_STEP_L [4]  = '{1, 10, 100, 1000};
	localparam int unsigned FACTOR_C [4]    = '{1000, 100, 10, 1};
	// One accumulator unit in litre x hundredth x centi-degree
	localparam int unsigned FRAC_MOD        = 10_000_000;
	localparam int unsigned CARRY_MAX       = 8;

	typedef enum logic [1:0] {
		ST_USER   = 2'b00,
		ST_TEST   = 2'b01,
		ST_PROMPT = 2'b10
	} menu_state_t;

endpackage : meter_test_loop_pkg

// File: hw/meter_test_loop_accumulators.sv
// Verification-mode menu and high-resolution energy, volume, temp accumulators
`timescale 1ns/100ps

module meter_test_loop_accumulators
	import meter_test_loop_pkg::*;
#(
	parameter int unsigned TICK_CYCLES_P  = TICK_CYCLES,
	parameter int unsigned TIMEOUT_MS_P   = TEST_TIMEOUT_MS,
	parameter int unsigned EXIT_HOLD_MS_P = EXIT_HOLD_MS,
	parameter int unsigned LONG_MS_P      = LONG_PRESS_MS,
	parameter int unsigned ACC_W          = 32,
	parameter int unsigned TEMP_W         = 16,
	parameter int unsigned INC_W          = 16
) (
	// Clock and total reset
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_b_i,
	// Front key and seal contacts (pins)
	input  wire logic                  key_i,
	input  wire logic                  seal_short_i,
	// Requests from the meter control logic
	input  wire logic                  test_enter_req_i,
	input  wire logic                  reconfig_req_i,
	// Measurements from the integration logic
	input  wire logic                  integration_i,
	input  wire logic [INC_W-1:0]      heat_wh_inc_i,
	input  wire logic [INC_W-1:0]      cool_wh_inc_i,
	input  wire logic [INC_W-1:0]      vol_10ml_inc_i,
	input  wire logic                  vol_count_i,
	input  wire logic [TEMP_W-1:0]     inlet_temperature_i,
	input  wire logic [TEMP_W-1:0]     outlet_temperature_i,
	input  wire logic [1:0]            flow_config_code_res_i,
	input  wire logic                  inlet_err_i,
	input  wire logic                  outlet_err_i,
	input  wire logic                  flow_err_i,
	// Display state
	output logic                       test_mode_o,
	output logic [MENU_W-1:0]          menu_index_o,
	output logic                       secondary_o,
	output logic                       exit_prompt_o,
	output logic                       user_menu_restart_o,
	// Reconfiguration log
	output logic [RECONFIG_W-1:0]      reconfig_count_o,
	output logic                       reconfig_ack_o,
	output logic                       reconfig_refused_o,
	// High-resolution registers
	output logic [ACC_W-1:0]           heat_energy_register_o,
	output logic [ACC_W-1:0]           cooling_energy_register_o,
	output logic [ACC_W-1:0]           volume_register_o,
	output logic [ACC_W-1:0]           inlet_temp_volume_accumulator_o,
	output logic [ACC_W-1:0]           outlet_temp_volume_accumulator_o
);

	localparam int unsigned TICK_W = $clog2(TICK_CYCLES_P + 1);
	localparam int unsigned TOUT_W = $clog2(TIMEOUT_MS_P + 1);
	localparam int unsigned HOLD_W = $clog2(EXIT_HOLD_MS_P + 1);

	// Adds an addend into a fraction below FRAC_MOD, returns carry and rest
	function automatic logic [35:0] frac_add(
		input logic [31:0] frac,
		input logic [31:0] addend
	);
		logic [31:0] sum;
		logic [3:0]  carry;
		sum   = frac + addend;
		carry = 4'h0;
		for (int k = 0; k < CARRY_MAX; k++) begin
			if (sum >= FRAC_MOD) begin
				sum   = sum - FRAC_MOD;
				carry = carry + 4'h1;
			end
		end
		frac_add = {carry, sum};
	endfunction : frac_add

	// Pin synchronisers
	logic                 key_meta_r;
	logic                 key_sync_r;
	logic                 key_prev_r;
	logic                 seal_meta_r;
	logic                 seal_sync_r;

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			key_meta_r  <= 1'b0;
			key_sync_r  <= 1'b0;
			key_prev_r  <= 1'b0;
			seal_meta_r <= 1'b0;
			seal_sync_r <= 1'b0;
		end else begin
			key_meta_r  <= key_i;
			key_sync_r  <= key_meta_r;
			key_prev_r  <= key_sync_r;
			seal_meta_r <= seal_short_i;
			seal_sync_r <= seal_meta_r;
		end
	end

	wire key_press   = key_sync_r && !key_prev_r;
	wire key_release = !key_sync_r && key_prev_r;

	// Millisecond tick divider
	logic [TICK_W-1:0]    tick_cnt_r;
	logic                 tick_r;

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b0;
		end else if (tick_cnt_r == TICK_W'(TICK_CYCLES_P - 1)) begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + TICK_W'(1);
			tick_r     <= 1'b0;
		end
	end

	// Key hold measurement; a press begun before entry is never acted on
	logic [HOLD_W-1:0]    hold_ms_r;
	logic                 press_seen_r;
	menu_state_t          state_r;

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			hold_ms_r    <= '0;
			press_seen_r <= 1'b0;
		end else if (state_r == ST_USER || key_release) begin
			hold_ms_r    <= '0;
			press_seen_r <= 1'b0;
		end else if (key_press) begin
			hold_ms_r    <= '0;
			press_seen_r <= 1'b1;
		end else if (tick_r && press_seen_r &&
		             hold_ms_r != HOLD_W'(EXIT_HOLD_MS_P)) begin
			hold_ms_r    <= hold_ms_r + HOLD_W'(1);
		end
	end

	wire rel_valid  = key_release && press_seen_r;
	wire is_long    = hold_ms_r >= HOLD_W'(LONG_MS_P);
	wire hold_done  = hold_ms_r == HOLD_W'(EXIT_HOLD_MS_P);

	// Test mode timeout
	logic [TOUT_W-1:0]    test_ms_r;
	wire                  timeout = test_ms_r == TOUT_W'(TIMEOUT_MS_P);

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i || state_r == ST_USER) begin
			test_ms_r <= '0;
		end else if (tick_r && !timeout) begin
			test_ms_r <= test_ms_r + TOUT_W'(1);
		end
	end

	// Menu state machine
	logic [MENU_W-1:0]    index_r;
	logic                 sec_r;

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			state_r             <= ST_USER;
			index_r             <= MENU_FIRST;
			sec_r               <= 1'b0;
			user_menu_restart_o <= 1'b0;
		end else begin
			user_menu_restart_o <= 1'b0;
			case (state_r)
				ST_USER: begin
					if (test_enter_req_i && seal_sync_r) begin
						state_r <= ST_TEST;
						index_r <= MENU_FIRST;
						sec_r   <= 1'b0;
					end
				end
				ST_TEST: begin
					if (timeout) begin
						state_r             <= ST_USER;
						user_menu_restart_o <= 1'b1;
					end else if (hold_done) begin
						state_r <= ST_PROMPT;
					end else if (rel_valid && !is_long) begin
						sec_r <= 1'b0;
						if (index_r == MENU_LAST) begin
							index_r <= MENU_FIRST;
						end else begin
							index_r <= index_r + MENU_W'(1);
						end
					end else if (rel_valid && index_r <= MENU_LAST_SEC) begin
						sec_r <= !sec_r;
					end
				end
				ST_PROMPT: begin
					if (timeout || rel_valid) begin
						state_r             <= ST_USER;
						user_menu_restart_o <= 1'b1;
					end
				end
				default: begin
					state_r <= ST_USER;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			test_mode_o   <= 1'b0;
			menu_index_o  <= MENU_FIRST;
			secondary_o   <= 1'b0;
			exit_prompt_o <= 1'b0;
		end else begin
			test_mode_o   <= state_r != ST_USER;
			menu_index_o  <= index_r;
			secondary_o   <= sec_r && state_r == ST_TEST;
			exit_prompt_o <= state_r == ST_PROMPT;
		end
	end

	// Reconfiguration log; refused requests leave the count unchanged
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			reconfig_count_o   <= '0;
			reconfig_ack_o     <= 1'b0;
			reconfig_refused_o <= 1'b0;
		end else begin
			reconfig_ack_o     <= 1'b0;
			reconfig_refused_o <= 1'b0;
			if (reconfig_req_i) begin
				if (reconfig_count_o < RECONFIG_W'(RECONFIG_MAX)) begin
					reconfig_count_o <= reconfig_count_o + RECONFIG_W'(1);
					reconfig_ack_o   <= 1'b1;
				end else begin
					reconfig_refused_o <= 1'b1;
				end
			end
		end
	end

	// Heat, cooling and volume: any measurement error stops energy counting
	wire any_err = inlet_err_i || outlet_err_i || flow_err_i;

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			heat_energy_register_o    <= '0;
			cooling_energy_register_o <= '0;
			volume_register_o         <= '0;
		end else if (integration_i) begin
			if (!any_err) begin
				heat_energy_register_o    <= heat_energy_register_o +
					ACC_W'(heat_wh_inc_i) * ACC_W'(HR_ENERGY_STEP_WH);
				cooling_energy_register_o <= cooling_energy_register_o +
					ACC_W'(cool_wh_inc_i) * ACC_W'(HR_ENERGY_STEP_WH);
			end
			if (!flow_err_i) begin
				volume_register_o <= volume_register_o +
					ACC_W'(vol_10ml_inc_i);
			end
		end
	end

	// Volume step times factor is one weight per resolution code
	logic [31:0]          weight_w;

	always_comb begin
		weight_w = 32'(VOL_STEP_L[flow_config_code_res_i] *
		               FACTOR_C[flow_config_code_res_i]);
	end

	// Inlet and outlet accumulators share one structure
	logic [TEMP_W-1:0]    temp_w [2];
	logic                 err_w [2];
	logic [ACC_W-1:0]     acc_r [2];

	assign temp_w[0] = inlet_temperature_i;
	assign temp_w[1] = outlet_temperature_i;
	assign err_w[0]  = inlet_err_i || flow_err_i;
	assign err_w[1]  = outlet_err_i || flow_err_i;

	for (genvar g = 0; g < 2; g++) begin : g_acc
		// Sub-unit residue kept so small steps at coarse scale are not lost
		logic [31:0]  frac_r;
		logic [35:0]  step_w;

		always_comb begin
			step_w = frac_add(frac_r, weight_w * 32'(temp_w[g]));
		end

		always_ff @(posedge core_clk_i) begin
			if (!rst_b_i) begin
				frac_r   <= '0;
				acc_r[g] <= '0;
			end else if (vol_count_i && !err_w[g]) begin
				frac_r   <= step_w[31:0];
				acc_r[g] <= acc_r[g] + ACC_W'(step_w[35:32]);
			end
		end
	end

	assign inlet_temp_volume_accumulator_o  = acc_r[0];
	assign outlet_temp_volume_accumulator_o = acc_r[1];

endmodule : meter_test_loop_accumulators

// File: tb/meter_key_model.sv
// Technician model: presses the front key for a set number of ms
`timescale 1ns/100ps
module meter_key_model #(
	parameter int unsigned MS_CYC = 10
) (
	// Clock and press request
	input  wire logic       core_clk_i,
	input  wire logic       go_i,
	input  wire logic [7:0] hold_ms_i,
	// Key pin
	output logic            key_o = 1'b0
);
	int unsigned cnt_r = 0;

	// Clean edges only, since the key path has no debounce
	always @(posedge core_clk_i) begin
		if (go_i && !key_o) begin
			key_o <= 1'b1;
			cnt_r <= hold_ms_i * MS_CYC;
		end else if (key_o) begin
			if (cnt_r == 0)
				key_o <= 1'b0;
			else
				cnt_r <= cnt_r - 1;
		end
	end
endmodule : meter_key_model

// File: tb/meter_test_loop_sva.sv
// Port checker for the test-loop menu and high-resolution registers
`timescale 1ns/100ps
module meter_test_loop_sva #(
	parameter int unsigned ACC_W = 32,
	parameter int unsigned INC_W = 16
) (
	input wire logic             core_clk_i,
	input wire logic             rst_b_i,
	input wire logic             seal_short_i,
	input wire logic             test_enter_req_i,
	input wire logic             reconfig_req_i,
	input wire logic             integration_i,
	input wire logic [INC_W-1:0] heat_wh_inc_i,
	input wire logic [INC_W-1:0] vol_10ml_inc_i,
	input wire logic             inlet_err_i,
	input wire logic             outlet_err_i,
	input wire logic             flow_err_i,
	input wire logic             test_mode_o,
	input wire logic [2:0]       menu_index_o,
	input wire logic             secondary_o,
	input wire logic             exit_prompt_o,
	input wire logic             user_menu_restart_o,
	input wire logic [4:0]       reconfig_count_o,
	input wire logic             reconfig_ack_o,
	input wire logic             reconfig_refused_o,
	input wire logic [ACC_W-1:0] heat_energy_register_o,
	input wire logic [ACC_W-1:0] volume_register_o,
	input wire logic [ACC_W-1:0] inlet_temp_volume_accumulator_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_free;
		reconfig_req_i && reconfig_count_o < 5'h19;
	endsequence
	sequence s_full;
		reconfig_req_i && reconfig_count_o == 5'h19;
	endsequence

	chk_reconfig_ack:
	assert property (s_free |=> reconfig_ack_o
		&& reconfig_count_o == $past(reconfig_count_o) + 5'h01)
		else $error("reconfig not acknowledged");
	chk_reconfig_refuse:
	assert property (s_full |=> reconfig_refused_o && !reconfig_ack_o
		&& reconfig_count_o == 5'h19) else $error("reconfig not refused");
	chk_seal_entry:
	assert property ($rose(test_mode_o) |-> $past(seal_short_i, 4)
		&& $past(test_enter_req_i, 2)) else $error("bad test entry");
	// The restart pulse leads the fall of test mode by one cycle
	chk_restart_exit:
	assert property (user_menu_restart_o |-> test_mode_o
		##1 (!test_mode_o && !user_menu_restart_o))
		else $error("restart without exit");
	chk_menu_range:
	assert property (test_mode_o |-> menu_index_o inside {[3'h1:3'h6]}
		&& (!secondary_o || menu_index_o <= 3'h3)) else $error("bad index");
	chk_prompt_mode:
	assert property (exit_prompt_o |-> test_mode_o)
		else $error("prompt outside test");
	chk_energy_add:
	assert property (integration_i && !inlet_err_i && !outlet_err_i
		&& !flow_err_i |=> heat_energy_register_o ==
		$past(heat_energy_register_o) + $past(heat_wh_inc_i)
		&& volume_register_o == $past(volume_register_o)
		+ $past(vol_10ml_inc_i)) else $error("bad register step");
	chk_acc_freeze:
	assert property (inlet_err_i || flow_err_i
		|=> $stable(inlet_temp_volume_accumulator_o))
		else $error("inlet accumulator moved on error");
	chk_reg_hold:
	assert property ($past(rst_b_i) |-> heat_energy_register_o >=
		$past(heat_energy_register_o) && volume_register_o >=
		$past(volume_register_o)) else $error("register dropped");
endmodule : meter_test_loop_sva

bind meter_test_loop_accumulators meter_test_loop_sva #(
	.ACC_W(ACC_W),
	.INC_W(INC_W)
) u_sva (.core_clk_i, .rst_b_i, .seal_short_i, .test_enter_req_i,
	.reconfig_req_i, .integration_i, .heat_wh_inc_i, .vol_10ml_inc_i,
	.inlet_err_i, .outlet_err_i, .flow_err_i, .test_mode_o, .menu_index_o,
	.secondary_o, .exit_prompt_o, .user_menu_restart_o, .reconfig_count_o,
	.reconfig_ack_o, .reconfig_refused_o, .heat_energy_register_o,
	.volume_register_o, .inlet_temp_volume_accumulator_o);

// File: tb/meter_test_loop_accumulators_tb_top.sv
// Self-checking bench for the test-loop menu and accumulators
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
	n_fail++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); \
	end end
module meter_test_loop_accumulators_tb_top;
	logic        core_clk_i = 1'b0, rst_b_i = 1'b0, key_i, go = 1'b0;
	logic        seal_short_i = 1'b0, test_enter_req_i = 1'b0;
	logic        reconfig_req_i = 1'b0, integration_i = 1'b0;
	logic        vol_count_i = 1'b0, inlet_err_i = 1'b0;
	logic        outlet_err_i = 1'b0, flow_err_i = 1'b0;
	logic [15:0] heat_wh_inc_i = 16'h0, cool_wh_inc_i = 16'h0;
	logic [15:0] vol_10ml_inc_i = 16'h0, inlet_temperature_i = 16'h0;
	logic [15:0] outlet_temperature_i = 16'h0;
	logic [1:0]  flow_config_code_res_i = 2'h0;
	logic [7:0]  hold_ms = 8'h0;
	logic        test_mode_o, secondary_o, exit_prompt_o, saw_p, saw_r;
	logic        user_menu_restart_o, reconfig_ack_o, reconfig_refused_o;
	logic [2:0]  menu_index_o;
	logic [4:0]  reconfig_count_o;
	logic [31:0] heat_energy_register_o, cooling_energy_register_o;
	logic [31:0] volume_register_o, inlet_temp_volume_accumulator_o;
	logic [31:0] outlet_temp_volume_accumulator_o;
	logic [31:0] e_heat, e_cool, e_vol, e_in, e_out;
	int          n_fail = 0, total_checks = 0, cycles = 0;

	// Shortened time base: 1 ms is 10 cycles
	meter_test_loop_accumulators #(.TICK_CYCLES_P(10), .TIMEOUT_MS_P(150),
		.EXIT_HOLD_MS_P(8), .LONG_MS_P(3)) u_dut (.core_clk_i, .rst_b_i,
		.key_i, .seal_short_i, .test_enter_req_i, .reconfig_req_i,
		.integration_i, .heat_wh_inc_i, .cool_wh_inc_i, .vol_10ml_inc_i,
		.vol_count_i, .inlet_temperature_i, .outlet_temperature_i,
		.flow_config_code_res_i, .inlet_err_i, .outlet_err_i, .flow_err_i,
		.test_mode_o, .menu_index_o, .secondary_o, .exit_prompt_o,
		.user_menu_restart_o, .reconfig_count_o, .reconfig_ack_o,
		.reconfig_refused_o, .heat_energy_register_o,
		.cooling_energy_register_o, .volume_register_o,
		.inlet_temp_volume_accumulator_o, .outlet_temp_volume_accumulator_o);
	meter_key_model #(.MS_CYC(10)) u_key (.core_clk_i, .go_i(go),
		.hold_ms_i(hold_ms), .key_o(key_i));

	initial forever #2.5 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 12000) begin
			n_fail++;
			print_verdict();
		end
	end

	task automatic print_verdict;
		if (n_fail == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask : cyc
	task automatic watch(input int n);
		saw_p = 1'b0;
		saw_r = 1'b0;
		repeat (n) begin
			cyc(1);
			saw_p |= exit_prompt_o;
			saw_r |= user_menu_restart_o;
		end
	endtask : watch
	task automatic press(input logic [7:0] ms);
		hold_ms = ms;
		go = 1'b1;
		cyc(1);
		go = 1'b0;
		watch(int'(ms) * 10 + 14);
	endtask : press
	task automatic enter(input logic s);
		seal_short_i = s;
		cyc(4);
		test_enter_req_i = 1'b1;
		cyc(1);
		test_enter_req_i = 1'b0;
		cyc(4);
	endtask : enter
	task automatic t_reset;
		rst_b_i = 1'b0;
		cyc(6);
		rst_b_i = 1'b1;
		cyc(1);
		{e_heat, e_cool, e_vol, e_in, e_out} = '0;
		`CHK({heat_energy_register_o, cooling_energy_register_o,
			volume_register_o, inlet_temp_volume_accumulator_o,
			outlet_temp_volume_accumulator_o}, 160'h0)
		`CHK({test_mode_o, reconfig_count_o, menu_index_o}, 9'h001)
	endtask : t_reset
	task automatic integ(input int n, input logic en);
		integration_i = 1'b1;
		cyc(n);
		integration_i = 1'b0;
		cyc(1);
		e_heat += en ? 32'(n) * 32'hffff : 32'h0;
		e_cool += en ? 32'(n) * 32'h5 : 32'h0;
		e_vol += 32'(n) * 32'h7;
		`CHK({heat_energy_register_o, cooling_energy_register_o,
			volume_register_o}, {e_heat, e_cool, e_vol})
	endtask : integ
	task automatic counts(input logic [31:0] din, input logic [31:0] dout);
		vol_count_i = 1'b1;
		cyc(100);
		vol_count_i = 1'b0;
		cyc(1);
		e_in += din;
		e_out += dout;
		`CHK({volume_register_o, inlet_temp_volume_accumulator_o,
			outlet_temp_volume_accumulator_o},
			{e_vol, e_in, e_out})
	endtask : counts
	task automatic t_acc;
		heat_wh_inc_i = 16'hffff;
		cool_wh_inc_i = 16'h5;
		vol_10ml_inc_i = 16'h7;
		integ(3, 1'b1);
		inlet_err_i = 1'b1;
		integ(2, 1'b0);
		inlet_err_i = 1'b0;
		// Each 100 counts adds 95 and 45 exactly, whatever the resolution
		inlet_temperature_i = 16'h251c;
		outlet_temperature_i = 16'h1194;
		for (int r = 0; r < 4; r++) begin
			flow_config_code_res_i = 2'(r);
			// A reader averages only over a full 100-count volume stretch
			counts(32'h5f, 32'h2d);
		end
		outlet_err_i = 1'b1;
		counts(32'h5f, 32'h0);
		outlet_err_i = 1'b0;
		flow_err_i = 1'b1;
		integration_i = 1'b1;
		counts(32'h0, 32'h0);
		integration_i = 1'b0;
		flow_err_i = 1'b0;
		`CHK(volume_register_o, e_vol)
	endtask : t_acc
	task automatic t_menu;
		enter(1'b0);
		`CHK(test_mode_o, 1'b0)
		enter(1'b1);
		`CHK({test_mode_o, menu_index_o}, 4'h9)
		for (int i = 2; i <= 7; i++) begin
			press(8'h1);
			`CHK(menu_index_o, i == 7 ? 3'h1 : 3'(i))
		end
		press(8'h5);
		`CHK({secondary_o, test_mode_o}, 2'h3)
		press(8'h5);
		`CHK(secondary_o, 1'b0)
		for (int i = 0; i < 3; i++)
			press(8'h1);
		press(8'h5);
		`CHK({menu_index_o, secondary_o}, 4'h8)
		press(8'hb);
		`CHK({saw_p, saw_r, test_mode_o}, 3'h6)
	endtask : t_menu
	task automatic t_timeout;
		enter(1'b1);
		watch(1400);
		`CHK({saw_r, test_mode_o}, 2'h1)
		watch(200);
		`CHK({saw_r, test_mode_o}, 2'h2)
	endtask : t_timeout
	task automatic t_reconfig;
		reconfig_req_i = 1'b1;
		for (int i = 0; i < 26; i++) begin
			cyc(1);
			`CHK({reconfig_ack_o, reconfig_refused_o},
				i < 25 ? 2'h2 : 2'h1)
		end
		reconfig_req_i = 1'b0;
		`CHK(reconfig_count_o, 5'h19)
		`CHK(heat_energy_register_o, e_heat)
	endtask : t_reconfig

	initial begin
		t_reset();
		t_acc();
		t_menu();
		t_timeout();
		t_reconfig();
		t_reset();
		print_verdict();
	end
endmodule : meter_test_loop_accumulators_tb_top
